// File: src/trs_top.sv
/*
  triple rail supervisor and sequencer: supply sequencing, channel gating,
  power-good hold-off and flag, apb register slave.
  assumes comparator levels come asynchronously and the open-drain flag
  is pulled up outside; output enable high pulls the flag low.
*/
`timescale 1ns/1ps
`default_nettype none
module trs_top
  import trs_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire trs_pkg::trs_sense_t sense,
  output trs_pkg::trs_drive_t    drive,
  output logic                   pump_enable,
  output logic                   power_good_n_o,
  output logic                   power_good_n_oe
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  trs_sense_t sense_meta_ff;
  trs_sense_t s_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sense_meta_ff <= '0;
      s_ff          <= '0;
    end
    else
    begin
      sense_meta_ff <= sense;
      s_ff          <= sense_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // supply sequencing
  // ----------------------------------------------------------------
  trs_sup_t sup_ff;
  logic     bias_ext_ff;
  logic     uv_ok;
  logic     fault;

  // external logic supply only counts once the rails are up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bias_ext_ff <= 1'b0;
    else if (sup_ff != SUP_RUN)
      bias_ext_ff <= 1'b0;
    else
      bias_ext_ff <= s_ff.logic_supply_external;
  end

  assign uv_ok = bias_ext_ff ? s_ff.input_stop_external_ok
                             : s_ff.input_stop_internal_ok;
  assign fault = s_ff.thermal_shutdown || !uv_ok;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sup_ff <= SUP_OFF;
    else
    begin
      unique case (sup_ff)
        SUP_OFF:
          if (s_ff.input_start_ok && !s_ff.thermal_shutdown)
            sup_ff <= SUP_PUMP;
        SUP_PUMP:
          if (s_ff.thermal_shutdown || !s_ff.input_stop_internal_ok)
            sup_ff <= SUP_OFF;
          else if (s_ff.input_pump_start_ok)
            sup_ff <= SUP_RUN;
        SUP_RUN:
          if (fault)
            sup_ff <= SUP_OFF;
      endcase
    end
  end

  assign pump_enable = (sup_ff != SUP_OFF);

  // ----------------------------------------------------------------
  // ramp divider and channels
  // ----------------------------------------------------------------
  logic [15:0] ramp_div_ff;
  logic        ramp_step;
  logic        start_ok;
  logic [2:0]  ramped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ramp_div_ff <= 16'h0000;
    else if (ramp_step)
      ramp_div_ff <= 16'h0000;
    else
      ramp_div_ff <= ramp_div_ff + 16'h0001;
  end

  assign ramp_step = (ramp_div_ff == 16'(RAMP_STEP_CYC - 1));
  // a fault leaving sup_ff in RUN for one cycle must not start anything
  assign start_ok = (sup_ff == SUP_RUN) && !fault;

  trs_channel u_ch0 (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (s_ff.channel_enable[0]),
    .start_ok (start_ok),
    .step_en  (ramp_step),
    .run_ff   (drive.run[0]),
    .ref_ff   (drive.ref0),
    .ramped   (ramped[0])
  );

  trs_channel u_ch1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (s_ff.channel_enable[1]),
    .start_ok (start_ok),
    .step_en  (ramp_step),
    .run_ff   (drive.run[1]),
    .ref_ff   (drive.ref1),
    .ramped   (ramped[1])
  );

  trs_channel u_ch2 (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (s_ff.channel_enable[2]),
    .start_ok (start_ok),
    .step_en  (ramp_step),
    .run_ff   (drive.run[2]),
    .ref_ff   (drive.ref2),
    .ramped   (ramped[2])
  );

  // ----------------------------------------------------------------
  // power-good evaluation
  // ----------------------------------------------------------------
  trs_pg_t     pg_ff;
  logic [2:0]  en_prev_ff;
  logic [2:0]  en;
  logic        en_rise;
  logic        any_en;
  logic        all_85;
  logic        any_80;
  logic        pg_block;
  logic [31:0] hold_cnt_ff;
  logic [31:0] hold_target;
  logic        hold_done;
  logic [15:0] holdoff_cap_ff;

  assign en      = s_ff.channel_enable & drive.run;
  assign any_en  = |s_ff.channel_enable;
  assign all_85  = &(~s_ff.channel_enable | s_ff.fb_above_85);
  assign any_80  = |(s_ff.channel_enable & s_ff.fb_below_80);
  assign en_rise = |(s_ff.channel_enable & ~en_prev_ff);
  assign pg_block = !any_en || !s_ff.input_warning_ok || (en != s_ff.channel_enable);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_prev_ff <= 3'b000;
    else
      en_prev_ff <= s_ff.channel_enable;
  end

  // hold-off length in cycles, never below one
  function automatic logic [31:0] holdoff_cycles(input logic [15:0] cap_nf);
    logic [31:0] prod;
    prod = 32'(cap_nf) * 32'(HOLDOFF_CYC_PER_NF);
    return (prod == 32'h0000_0000) ? 32'h0000_0001 : prod;
  endfunction

  assign hold_target = holdoff_cycles(holdoff_cap_ff);
  assign hold_done   = (hold_cnt_ff == hold_target - 32'h0000_0001);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pg_ff <= PG_WAIT;
    else if (pg_block)
      pg_ff <= PG_WAIT;
    else
    begin
      unique case (pg_ff)
        PG_WAIT:
          if (all_85)
            pg_ff <= PG_HOLD;
        PG_HOLD:
          if (!all_85 || en_rise)
            pg_ff <= PG_WAIT;
          else if (hold_done)
            pg_ff <= any_80 ? PG_WAIT : PG_GOOD;
        PG_GOOD:
          if (any_80 || en_rise)
            pg_ff <= PG_WAIT;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_cnt_ff <= 32'h0000_0000;
    else if (pg_ff != PG_HOLD)
      hold_cnt_ff <= 32'h0000_0000;
    else if (!hold_done)
      hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
  end

  // open drain: pull low unless good; the clear acts combinationally
  assign power_good_n_o  = 1'b0;
  assign power_good_n_oe = !(pg_ff == PG_GOOD && !pg_block && !any_80 && !en_rise);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        addr_ok;
  logic [31:0] status_word;

  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign addr_ok = (paddr == REG_HOLDOFF_CAP) || (paddr == REG_STATUS)
                || (paddr == REG_HOLD_COUNT);
  assign pready  = 1'b1;
  assign pslverr = access && !addr_ok;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ST_RUN_LSB +: 3]    = drive.run;
    status_word[ST_RAMPED_LSB +: 3] = ramped;
    status_word[ST_PG_BIT]          = !power_good_n_oe;
    status_word[ST_SUP_LSB +: 2]    = sup_ff;
    status_word[ST_FAULT_BIT]       = fault;
    status_word[ST_BIASX_BIT]       = bias_ext_ff;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      holdoff_cap_ff <= HOLDOFF_CAP_RST;
    else if (access && pwrite && paddr == REG_HOLDOFF_CAP)
      holdoff_cap_ff <= pwdata[15:0];
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
    begin
      unique case (paddr)
        REG_HOLDOFF_CAP: prdata <= {16'h0000, holdoff_cap_ff};
        REG_STATUS:      prdata <= status_word;
        REG_HOLD_COUNT:  prdata <= hold_cnt_ff;
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hold_start;
    (pg_ff == PG_WAIT) ##1 (pg_ff == PG_HOLD);
  endsequence

  sequence s_hold_expire;
    (pg_ff == PG_HOLD) && hold_done && !any_80 && !pg_block && all_85 && !en_rise;
  endsequence

  a_start_gate: assert property (
    $rose(drive.run[0]) |-> $past(s_ff.channel_enable[0] && sup_ff == SUP_RUN
                                  && !s_ff.thermal_shutdown))
    else $error("channel started without its conditions");

  a_fault_stops_all: assert property (
    fault |=> drive.run == 3'b000)
    else $error("channel running through a fault");

  a_hold_needs_85: assert property (
    s_hold_start |-> $past(all_85))
    else $error("hold-off started before all channels at 85 percent");

  a_pg_rise_cause: assert property (
    s_hold_expire |=> pg_ff == PG_GOOD)
    else $error("flag not raised at hold-off expiry");

  a_pg_only_expiry: assert property (
    $rose(pg_ff == PG_GOOD) |-> $past(pg_ff == PG_HOLD && hold_done))
    else $error("flag raised without hold-off expiry");

  a_drop_clears_now: assert property (
    any_80 |-> power_good_n_oe ##1 (pg_ff != PG_GOOD))
    else $error("flag high with a channel below 80 percent");

  a_new_enable_clears: assert property (
    en_rise |-> power_good_n_oe ##1 (pg_ff != PG_GOOD))
    else $error("new enable left flag high");

  a_none_enabled: assert property (
    !any_en |-> power_good_n_oe ##1 pg_ff == PG_WAIT)
    else $error("flag high with no channel enabled");

  a_warning_clears: assert property (
    !s_ff.input_warning_ok && sup_ff == SUP_RUN && !fault |-> power_good_n_oe ##1 sup_ff == SUP_RUN)
    else $error("warning level mishandled");

  a_pump_first: assert property (
    $rose(sup_ff == SUP_RUN) |-> $past(sup_ff == SUP_PUMP && s_ff.input_pump_start_ok))
    else $error("channels released before pump threshold");

endmodule
`default_nettype wire

// File: src/trs_pkg.sv
/*
  shared constants, types and register map of the triple rail supervisor
  and sequencer.
  assumes a single 20 MHz clock and analog comparators outside this logic.
*/
// Behaviour
// - start ramp only with enable, supplies, no overtemperature
// - ramp reference linearly from zero to 0.8 V
// - hold-off timer starts when all enabled reach 85%
// - at expiry flag high only if none below 80%
// - new enable clears flag, ramps, re-times hold-off
// - disabled channels never influence the flag
// - any enabled channel below 80% clears flag
// - recovery to 85% restarts hold-off from zero
// - dropout below 80% launches no new ramp
// - last channel disabled clears the flag
// - input below warning level clears flag, converters run
// - overtemperature or input undervoltage stops every channel
// - faults cleared, enabled channels restart with fresh ramp
// - overload alone never restarts a ramp
// - stop threshold follows logic supply source
// - first power-up uses internal bias start threshold
// - pump ramps first, channel ramps after combined threshold
// - hold-off proportional to capacitor, 2.131e5 s/F
// - each channel has its own active-high enable
package trs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int REF_TARGET_MV   = 800;
  localparam int REF_MV_PER_LSB  = 4;
  localparam int REF_FULL_INT    = REF_TARGET_MV / REF_MV_PER_LSB;
  localparam logic [7:0] REF_FULL_CODE = REF_FULL_INT[7:0];
  localparam int RAMP_TIME_US    = 1000;
  localparam int RAMP_STEP_CYC   = (CLK_HZ / 1_000_000) * RAMP_TIME_US / REF_FULL_INT;
  // 2.131e5 s per farad is the same figure as ns per nF
  localparam int HOLDOFF_NS_PER_NF  = 213_100;
  localparam int HOLDOFF_CYC_PER_NF = HOLDOFF_NS_PER_NF / CLK_PERIOD_NS;
  localparam logic [15:0] HOLDOFF_CAP_RST = 16'h01D6;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_HOLDOFF_CAP = 12'h0000;
  localparam logic [11:0] REG_STATUS      = 12'h0004;
  localparam logic [11:0] REG_HOLD_COUNT  = 12'h0008;
  localparam int ST_RUN_LSB   = 0;
  localparam int ST_RAMPED_LSB = 3;
  localparam int ST_PG_BIT    = 6;
  localparam int ST_SUP_LSB   = 7;
  localparam int ST_FAULT_BIT = 9;
  localparam int ST_BIASX_BIT = 10;

  typedef enum logic [1:0] {SUP_OFF, SUP_PUMP, SUP_RUN} trs_sup_t;
  typedef enum logic [1:0] {PG_WAIT, PG_HOLD, PG_GOOD} trs_pg_t;

  // comparator and pin levels arriving from outside the clock domain
  typedef struct packed {
    logic [2:0] channel_enable;
    logic [2:0] fb_above_85;
    logic [2:0] fb_below_80;
    logic       input_start_ok;
    logic       input_pump_start_ok;
    logic       input_stop_internal_ok;
    logic       input_stop_external_ok;
    logic       input_warning_ok;
    logic       logic_supply_external;
    logic       thermal_shutdown;
  } trs_sense_t;

  typedef struct packed {
    logic [2:0] run;
    logic [7:0] ref0;
    logic [7:0] ref1;
    logic [7:0] ref2;
  } trs_drive_t;

endpackage

// File: src/trs_channel.sv
/*
  one converter channel: run gate and soft-start reference ramp.
  assumes step_en is a one-cycle pulse from the shared ramp divider.
*/
`timescale 1ns/1ps
`default_nettype none
module trs_channel
  import trs_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic       start_ok,
  input  wire logic       step_en,
  output logic            run_ff,
  output logic [7:0]      ref_ff,
  output logic            ramped
);

  // ----------------------------------------------------------------
  // run gate
  // ----------------------------------------------------------------
  // feedback dropout is not an input here, so overload never restarts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_ff <= 1'b0;
    else
      run_ff <= enable && start_ok;
  end

  // ----------------------------------------------------------------
  // reference ramp
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ref_ff <= 8'h00;
    else if (!(enable && start_ok))
      ref_ff <= 8'h00;
    else if (step_en && run_ff && ref_ff != REF_FULL_CODE)
      ref_ff <= ref_ff + 8'h01;
  end

  assign ramped = (ref_ff == REF_FULL_CODE);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ramp_one_step: assert property (
    run_ff && $past(run_ff) |-> (ref_ff == $past(ref_ff)) || (ref_ff == $past(ref_ff) + 8'h01))
    else $error("reference moved by more than one step");

  a_no_dropout_restart: assert property (
    run_ff && enable && start_ok |=> ref_ff >= $past(ref_ff))
    else $error("reference fell while channel kept running");

endmodule
`default_nettype wire

// File: verif/trs_ctrl_model.sv
/*
  system controller model: drives the three channel enables and watches
  the power-good wire. assumes the wire is pulled up outside.
*/
`timescale 1ns/1ps
`default_nettype none
module trs_ctrl_model #(
  parameter int DLY = 2
)
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] want,
  input  wire logic       cycle_req,
  input  wire logic       power_good_n,
  output logic [2:0]      channel_enable,
  output logic            pg_seen
);
  logic [3:0]     off_cnt_ff;
  logic [DLY-1:0] pg_pipe_ff;

  // a slow reader: the flag reaches the controller late
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pg_pipe_ff <= '0;
    else
      pg_pipe_ff <= {pg_pipe_ff[DLY-2:0], power_good_n};
  assign pg_seen = pg_pipe_ff[DLY-1];

  // drop every enable for a while to force fresh ramps
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      off_cnt_ff <= 4'h0;
    else if (cycle_req)
      off_cnt_ff <= 4'h8;
    else if (off_cnt_ff != 4'h0)
      off_cnt_ff <= off_cnt_ff - 4'h1;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      channel_enable <= 3'h0;
    else
      channel_enable <= (off_cnt_ff != 4'h0) ? 3'h0 : want;
endmodule
`default_nettype wire

// File: verif/tb.sv
/*
  self-checking bench of the supervisor: apb tasks, comparator stimulus.
  assumes a 20 MHz clock and the controller model on the enables.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import trs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  trs_sense_t  sn, sense;
  trs_drive_t  drive;
  logic        pump_enable, pg_o, pg_oe, power_good_n, pg_seen, cyc_req;
  logic [2:0]  want, en;
  int          fails, compares, i;
  localparam int HC = HOLDOFF_CYC_PER_NF;

  assign power_good_n = pg_oe ? pg_o : 1'b1;
  always_comb
  begin
    sense = sn;
    sense.channel_enable = en;
  end

  trs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .drive(drive), .pump_enable(pump_enable),
    .power_good_n_o(pg_o), .power_good_n_oe(pg_oe));
  trs_ctrl_model ctrl_u (.pclk(pclk), .presetn(presetn), .want(want),
    .cycle_req(cyc_req), .power_good_n(power_good_n), .channel_enable(en),
    .pg_seen(pg_seen));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------
  task give_verdict;
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task lim(input int n, input int m);
    if (n >= m)
    begin
      fails++;
      give_verdict;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    lim(n, 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_run(input logic [2:0] r);
    for (i = 0; i < 40 && drive.run !== r; i++) @(posedge pclk);
    lim(i, 40);
  endtask
  // cycles from a comparator change until the flag is released
  task hold(input int lo, input int hi);
    for (i = 0; i < hi + 4 && pg_oe !== 1'b0; i++) @(posedge pclk);
    chk(i >= lo && i <= hi, 1);
    lim(i, hi + 4);
  endtask

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    fails = 0;
    compares = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, cyc_req, want} = '0;
    sn = '0;
    sn.input_warning_ok = 1'b1;
    sn.input_stop_internal_ok = 1'b1;
    sn.input_stop_external_ok = 1'b1;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    chk(pg_oe, 1);
    chk(pump_enable, 0);
    xfer(1'b0, REG_HOLDOFF_CAP, 32'h0000_0000);
    chk(rd, {16'h0000, HOLDOFF_CAP_RST});
    xfer(1'b0, 12'h0FF0, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(er, 1);
    // disabled channels sit below 80% until each one has been enabled
    want <= 3'b001;
    sn.fb_below_80 <= 3'b110;
    tick(10);
    chk(drive.run, 0);
    sn.input_start_ok <= 1'b1;
    tick(6);
    chk({pump_enable, drive.run}, 4'h8);
    sn.input_pump_start_ok <= 1'b1;
    wait_run(3'b001);
    for (i = 0; i < 25000 && drive.ref0 !== REF_FULL_CODE; i++) @(posedge pclk);
    chk(i >= 199 * RAMP_STEP_CYC && i <= 200 * RAMP_STEP_CYC + 4, 1);
    lim(i, 25000);
    xfer(1'b1, REG_HOLDOFF_CAP, 32'h0000_0001);
    sn.fb_above_85 <= 3'b001;
    hold(HC, HC + 6);
    tick(3);
    chk(pg_seen, 1);
    xfer(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0149);
    sn.fb_above_85 <= 3'b000;
    sn.fb_below_80 <= 3'b111;
    tick(4);
    chk(pg_oe, 1);
    chk({drive.run, drive.ref0}, {3'b001, REF_FULL_CODE});
    sn.fb_below_80 <= 3'b110;
    sn.fb_above_85 <= 3'b001;
    // timer runs from the third edge; read it at 11 counts, then wait out the rest
    tick(13);
    xfer(1'b0, REG_HOLD_COUNT, 32'h0000_0000);
    chk(rd, 32'h0000_000B);
    hold(HC - 16, HC - 10);
    xfer(1'b1, REG_HOLDOFF_CAP, 32'h0000_0000);
    want <= 3'b011;
    tick(30);
    chk({pg_oe, drive.run, drive.ref1 < 8'h08}, 5'b10111);
    sn.fb_above_85 <= 3'b011;
    sn.fb_below_80 <= 3'b100;
    hold(1, 8);
    sn.input_warning_ok <= 1'b0;
    tick(4);
    chk({pg_oe, drive.run}, 4'hB);
    sn.input_warning_ok <= 1'b1;
    hold(1, 8);
    // the supply source must settle before the internal level drops
    sn.logic_supply_external <= 1'b1;
    tick(6);
    xfer(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_054B);
    sn.input_stop_internal_ok <= 1'b0;
    tick(6);
    chk(drive.run, 3'b011);
    sn.input_stop_external_ok <= 1'b0;
    tick(6);
    chk({pg_oe, drive.run}, 4'h8);
    sn.input_stop_internal_ok <= 1'b1;
    sn.input_stop_external_ok <= 1'b1;
    wait_run(3'b011);
    chk(drive.ref0 < 8'h08, 1);
    sn.thermal_shutdown <= 1'b1;
    tick(6);
    chk({drive.run, drive.ref0, drive.ref1}, 0);
    sn.thermal_shutdown <= 1'b0;
    wait_run(3'b011);
    chk(drive.ref0 < 8'h08, 1);
    cyc_req <= 1'b1;
    tick(1);
    cyc_req <= 1'b0;
    tick(6);
    chk(drive.run, 0);
    wait_run(3'b011);
    chk(drive.ref1 < 8'h08, 1);
    hold(1, 40);
    want <= 3'b111;
    tick(30);
    chk({pg_oe, drive.run, drive.ref2 < 8'h08}, 5'b11111);
    sn.fb_above_85 <= 3'b111;
    sn.fb_below_80 <= 3'b000;
    hold(1, 8);
    want <= 3'b000;
    tick(5);
    chk({pg_oe, drive.run}, 4'h8);
    give_verdict;
  end
endmodule
`default_nettype wire
